// >>> core/vsc_map.vh
// Register map, field positions, reset values, codes and timing for the
// synchrocheck block. Definitions only; included by the design files.
`ifndef VSC_MAP_VH
`define VSC_MAP_VH

// ==========================================================
// Register byte offsets
`define VSC_CTRL_OFS      8'h00
`define VSC_LIVE_OFS      8'h04
`define VSC_DEAD_OFS      8'h08
`define VSC_MAXMAG_OFS    8'h0c
`define VSC_MAXANG_OFS    8'h10
`define VSC_MAXFRQ_OFS    8'h14
`define VSC_BKTIME_OFS    8'h18
`define VSC_STAT_OFS      8'h20
`define VSC_MAGD_OFS      8'h24
`define VSC_ANGD_OFS      8'h28
`define VSC_FRQD_OFS      8'h2c
`define VSC_CLOSE_OFS     8'h30
`define VSC_ROT_OFS       8'h34
`define VSC_PLACE_OFS     8'h38
`define VSC_NUM_CFG       7

// ==========================================================
// Control register fields
`define VSC_CTRL_USE      0
`define VSC_CTRL_SS3      1
`define VSC_CTRL_SS4      2
`define VSC_CTRL_VIEW     3
`define VSC_CTRL_REF      5
`define VSC_CTRL_AUTO     6
`define VSC_CTRL_VCOND    8
`define VSC_CTRL_MASK     32'h00000f7f
`define VSC_HALF_MASK     32'h0000ffff

// ==========================================================
// Reset values
`define VSC_CTRL_RST      32'h00000800
`define VSC_LIVE_RST      32'h00001f40
`define VSC_DEAD_RST      32'h00000bb8
`define VSC_MAXMAG_RST    32'h000001f4
`define VSC_MAXANG_RST    32'h000003e8
`define VSC_MAXFRQ_RST    32'h00000064
`define VSC_BKTIME_RST    32'h0000000a

// ==========================================================
// Status codes
`define VSC_CND_BLOCKED   3'h0
`define VSC_CND_OK        3'h1
`define VSC_CND_BYPASS    3'h2
`define VSC_CND_VCOND     3'h3
`define VSC_CND_MAG       3'h4
`define VSC_CND_ANG       3'h5
`define VSC_CND_FRQ       3'h6
`define VSC_CND_IDLE      3'h7
`define VSC_VST_UNDEF     3'h4
`define VSC_VST_NOTMON    3'h5
`define VSC_SW_STILL      2'h0
`define VSC_SW_DEPART     2'h1
`define VSC_SW_ENCL       2'h2

// ==========================================================
// Timing: estimates count in steps of this many microseconds
`define VSC_STEP_US       5000
`define VSC_ROT_NUM       (1000000000 / `VSC_STEP_US)
`define VSC_SAT_STEPS     (360 * 1000000 / `VSC_STEP_US)
`define VSC_FULL_TURN     36000

`endif

// >>> core/vsc_pair_cmp.v
// Compares one pair of voltages: differences, limits, live/dead state.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
`include "vsc_map.vh"

module vsc_pair_cmp
(
	input  wire        i_en,
	input  wire [15:0] i_mag_a,
	input  wire [15:0] i_mag_b,
	input  wire [15:0] i_ang_a,
	input  wire [15:0] i_ang_b,
	input  wire [19:0] i_frq_a,
	input  wire [19:0] i_frq_b,
	input  wire [15:0] i_live_th,
	input  wire [15:0] i_dead_th,
	input  wire [15:0] i_max_mag,
	input  wire [15:0] i_max_ang,
	input  wire [15:0] i_max_frq,
	input  wire [3:0]  i_vcond_mask,
	output wire [16:0] o_mag_diff,
	output wire [16:0] o_ang_diff,
	output wire [20:0] o_frq_diff,
	output wire [2:0]  o_volt_st,
	output wire        o_vcond_ok,
	output wire        o_mag_ok,
	output wire        o_ang_ok,
	output wire        o_frq_ok
);
	wire [16:0] mag_abs;
	wire [16:0] ang_abs;
	wire [20:0] frq_abs;
	wire        live_a;
	wire        live_b;
	wire        def_a;
	wire        def_b;

	// ==========================================================
	// Signed differences
	// magnitude difference
	assign o_mag_diff = {1'b0, i_mag_a} - {1'b0, i_mag_b};
	assign o_ang_diff = {i_ang_a[15], i_ang_a} - {i_ang_b[15], i_ang_b};
	assign o_frq_diff = {1'b0, i_frq_a} - {1'b0, i_frq_b};
	assign mag_abs = o_mag_diff[16] ? (17'h0 - o_mag_diff) : o_mag_diff;
	assign ang_abs = o_ang_diff[16] ? (17'h0 - o_ang_diff) : o_ang_diff;
	assign frq_abs = o_frq_diff[20] ? (21'h0 - o_frq_diff) : o_frq_diff;

	// ==========================================================
	// Limits
	// all three differences within limits
	assign o_mag_ok = i_en & (mag_abs <= {1'b0, i_max_mag});
	assign o_ang_ok = i_en & (ang_abs <= {1'b0, i_max_ang});
	assign o_frq_ok = i_en & (frq_abs <= {5'h00, i_max_frq});

	// ==========================================================
	// Live and dead
	// live above, dead below threshold
	assign live_a = i_mag_a > i_live_th;
	assign live_b = i_mag_b > i_live_th;
	assign def_a  = live_a | (i_mag_a < i_dead_th);
	assign def_b  = live_b | (i_mag_b < i_dead_th);
	assign o_volt_st = !i_en ? `VSC_VST_NOTMON :
		!(def_a & def_b) ? `VSC_VST_UNDEF : {1'b0, live_b, live_a};
	assign o_vcond_ok = i_en & def_a & def_b &
		i_vcond_mask[{live_b, live_a}];
endmodule // vsc_pair_cmp

`default_nettype wire

// >>> core/vsc_divider.v
// Serial restoring divider, one quotient bit per clock.
// Division by zero returns all ones, which callers treat as saturation.
`timescale 1ns/10ps
`default_nettype none

module vsc_divider
(
	input  wire        i_clk_sys,
	input  wire        i_sys_rst,
	input  wire        i_start,
	input  wire [39:0] i_num,
	input  wire [39:0] i_den,
	output reg         o_busy,
	output reg         o_done,
	output reg  [39:0] o_quo
);
	reg  [39:0] rem_r;
	reg  [39:0] den_r;
	reg  [5:0]  cnt_r;
	wire [40:0] trial;

	assign trial = {rem_r, o_quo[39]};

	// ==========================================================
	// Shift and subtract
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rem_r  <= 40'h0;
			den_r  <= 40'h0;
			cnt_r  <= 6'h0;
			o_quo  <= 40'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start && !o_busy)
			begin
				rem_r  <= 40'h0;
				den_r  <= i_den;
				o_quo  <= i_num;
				cnt_r  <= 6'd40;
				o_busy <= 1'b1;
			end
			else if (o_busy)
			begin
				if (trial >= {1'b0, den_r})
				begin
					rem_r <= trial[39:0] - den_r;
					o_quo <= {o_quo[38:0], 1'b1};
				end
				else
				begin
					rem_r <= trial[39:0];
					o_quo <= {o_quo[38:0], 1'b0};
				end
				cnt_r <= cnt_r - 6'd1;
				if (cnt_r == 6'd1)
				begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule // vsc_divider

`default_nettype wire

// >>> core/vsc_core.v
// Synchrocheck core: Wishbone classic slave, stage selection, checks,
// blocking and synchroswitching estimates.
// Assumes one measurement strobe per program cycle, synchronous inputs.
//
// Overview of operation
// - Synchronized only when all differences within limits
// - Live/dead from live and dead thresholds
// - Selected live/dead combination also required
// - Four channel fundamentals on fixed time base
// - Report condition status code
// - Report two-sided voltage status
// - Report signed magnitude difference, 0.01 percent
// - Report signed angle difference, 0.01 degree
// - Report signed frequency difference, 0.001 hertz
// - Switching status still, departing or enclosing
// - Estimated time to breaker close
// - Estimated full network rotation time
// - Present placement angle, 0.001 degree
// - Blocking input sampled each program cycle
// - Sync ok when synchronized and unblocked
// - Blocked instead when blocking precedes sync
// - Sync ok drops when blocking follows
// - Automatic close command with synchroswitching
// - Stage availability follows channel modes
`timescale 1ns/10ps
`default_nettype none
`include "vsc_map.vh"

module vsc_core
(
	input  wire        i_clk_sys,
	input  wire        i_sys_rst,
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [7:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	input  wire        i_meas_tick,
	input  wire [15:0] i_channel_one_fundamental,
	input  wire [15:0] i_channel_two_fundamental,
	input  wire [15:0] i_channel_three_fundamental,
	input  wire [15:0] i_channel_four_fundamental,
	input  wire [15:0] i_ch1_ang,
	input  wire [15:0] i_ch2_ang,
	input  wire [15:0] i_ch3_ang,
	input  wire [15:0] i_ch4_ang,
	input  wire [19:0] i_ch1_frq,
	input  wire [19:0] i_ch2_frq,
	input  wire [19:0] i_ch3_frq,
	input  wire [19:0] i_ch4_frq,
	input  wire        i_block,
	output reg         o_sync_ok_output,
	output reg         o_blocked,
	output reg         o_close_cmd
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ROT  = 3'b010;
	localparam [2:0] ST_CLS  = 3'b100;
	localparam [39:0] ROT_NUM   = `VSC_ROT_NUM;
	localparam [39:0] FULL_TURN = `VSC_FULL_TURN;
	localparam [39:0] SAT_STEPS = `VSC_SAT_STEPS;
	localparam [16:0] TURN17    = `VSC_FULL_TURN;

	// ==========================================================
	// Configuration storage
	reg  [31:0] cfg_r [0:`VSC_NUM_CFG-1];
	wire [31:0] ctrl = cfg_r[0] & `VSC_CTRL_MASK;
	wire [31:0] byte_mask;
	wire [2:0]  cfg_idx = i_wb_adr[4:2];
	wire        cfg_hit = (i_wb_adr[7:5] == 3'h0) && (cfg_idx != 3'h7);
	wire        wb_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;

	genvar j;
	generate
		for (j = 0; j < 4; j = j + 1)
		begin : g_lane
			assign byte_mask[8*j+7:8*j] = {8{i_wb_sel[j]}};
		end
	endgenerate

	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cfg_r[0] <= `VSC_CTRL_RST;
			cfg_r[1] <= `VSC_LIVE_RST;
			cfg_r[2] <= `VSC_DEAD_RST;
			cfg_r[3] <= `VSC_MAXMAG_RST;
			cfg_r[4] <= `VSC_MAXANG_RST;
			cfg_r[5] <= `VSC_MAXFRQ_RST;
			cfg_r[6] <= `VSC_BKTIME_RST;
		end
		else if (wb_req && i_wb_we && cfg_hit)
		begin
			cfg_r[cfg_idx] <= (cfg_r[cfg_idx] & ~byte_mask) |
				(i_wb_dat & byte_mask);
		end
	end

	wire        use_stage = ctrl[`VSC_CTRL_USE];
	wire        ss3       = ctrl[`VSC_CTRL_SS3];
	wire        ss4       = ctrl[`VSC_CTRL_SS4];
	wire [1:0]  view      = ctrl[`VSC_CTRL_VIEW+1:`VSC_CTRL_VIEW];
	wire        auto_close_switching = ctrl[`VSC_CTRL_AUTO];
	wire [3:0]  voltage_condition_select =
		ctrl[`VSC_CTRL_VCOND+3:`VSC_CTRL_VCOND];
	wire [15:0] bk_time = cfg_r[6][15:0];

	// ==========================================================
	// Stage selection
	// one reference serves stages one and two
	wire        use_ch2 = ctrl[`VSC_CTRL_REF];
	wire [15:0] ref_mag = use_ch2 ? i_channel_two_fundamental :
		i_channel_one_fundamental;
	wire [15:0] ref_ang = use_ch2 ? i_ch2_ang : i_ch1_ang;
	wire [19:0] ref_frq = use_ch2 ? i_ch2_frq : i_ch1_frq;
	reg         en;
	reg  [15:0] a_mag;
	reg  [15:0] b_mag;
	reg  [15:0] a_ang;
	reg  [15:0] b_ang;
	reg  [19:0] a_frq;
	reg  [19:0] b_frq;
	reg         a_is4;

	always @*
	begin
		a_is4 = 1'b0;
		en    = 1'b0;
		b_mag = ref_mag;
		b_ang = ref_ang;
		b_frq = ref_frq;
		if (ss3 && ss4)
		begin
			en    = use_stage && (view != 2'd0);
			a_is4 = (view == 2'd2);
			if (view == 2'd3)
			begin
				b_mag = i_channel_four_fundamental;
				b_ang = i_ch4_ang;
				b_frq = i_ch4_frq;
			end
		end
		else if (ss3 || ss4)
		begin
			en    = use_stage && (view == 2'd1);
			a_is4 = ss4;
		end
		a_mag = a_is4 ? i_channel_four_fundamental :
			i_channel_three_fundamental;
		a_ang = a_is4 ? i_ch4_ang : i_ch3_ang;
		a_frq = a_is4 ? i_ch4_frq : i_ch3_frq;
	end

	wire [16:0] mag_d;
	wire [16:0] ang_d;
	wire [20:0] frq_d;
	wire [2:0]  vst;
	wire        vc_ok;
	wire        m_ok;
	wire        a_ok;
	wire        f_ok;

	vsc_pair_cmp u_cmp
	(
		.i_en         (en),
		.i_mag_a      (a_mag),
		.i_mag_b      (b_mag),
		.i_ang_a      (a_ang),
		.i_ang_b      (b_ang),
		.i_frq_a      (a_frq),
		.i_frq_b      (b_frq),
		.i_live_th    (cfg_r[1][15:0]),
		.i_dead_th    (cfg_r[2][15:0]),
		.i_max_mag    (cfg_r[3][15:0]),
		.i_max_ang    (cfg_r[4][15:0]),
		.i_max_frq    (cfg_r[5][15:0]),
		.i_vcond_mask (voltage_condition_select),
		.o_mag_diff   (mag_d),
		.o_ang_diff   (ang_d),
		.o_frq_diff   (frq_d),
		.o_volt_st    (vst),
		.o_vcond_ok   (vc_ok),
		.o_mag_ok     (m_ok),
		.o_ang_ok     (a_ok),
		.o_frq_ok     (f_ok)
	);

	// ==========================================================
	// Measurement capture, once per program cycle
	reg  [16:0] mag_r;
	reg  [16:0] ang_r;
	reg  [20:0] frq_r;
	reg  [2:0]  vst_r;
	reg  [4:0]  flag_r;
	reg         block_r;
	reg         tick_d_r;
	reg         hold_r;
	reg  [2:0]  cond_r;

	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			mag_r    <= 17'h0;
			ang_r    <= 17'h0;
			frq_r    <= 21'h0;
			vst_r    <= `VSC_VST_NOTMON;
			flag_r   <= 5'h0;
			block_r  <= 1'b0;
			tick_d_r <= 1'b0;
		end
		else
		begin
			tick_d_r <= i_meas_tick;
			if (i_meas_tick)
			begin
				mag_r   <= mag_d;
				ang_r   <= ang_d;
				frq_r   <= frq_d;
				vst_r   <= vst;
				flag_r  <= {en, vc_ok, m_ok, a_ok, f_ok};
				block_r <= i_block;
			end
		end
	end

	wire sync_sat = &flag_r;

	// ==========================================================
	// Sync ok and blocking
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_sync_ok_output <= 1'b0;
			o_blocked        <= 1'b0;
			hold_r           <= 1'b0;
			cond_r           <= `VSC_CND_IDLE;
		end
		else if (tick_d_r)
		begin
			if (!sync_sat)
			begin
				o_sync_ok_output <= 1'b0;
				o_blocked        <= 1'b0;
				hold_r           <= 1'b0;
			end
			else if (!o_blocked)
			begin
				if (block_r)
				begin
					o_sync_ok_output <= 1'b0;
					hold_r <= hold_r | o_sync_ok_output;
					o_blocked <= ~o_sync_ok_output & ~hold_r;
				end
				else
				begin
					o_sync_ok_output <= 1'b1;
				end
			end
			// condition status by first failing check
			if (sync_sat && (o_blocked || (block_r &&
				!o_sync_ok_output && !hold_r)))
				cond_r <= `VSC_CND_BLOCKED;
			else if (sync_sat && !block_r)
				cond_r <= `VSC_CND_OK;
			else if (!flag_r[4])
				cond_r <= `VSC_CND_BYPASS;
			else if (!flag_r[3])
				cond_r <= `VSC_CND_IDLE;
			else if (!flag_r[2])
				cond_r <= `VSC_CND_VCOND;
			else if (!flag_r[1])
				cond_r <= `VSC_CND_MAG;
			else if (!flag_r[0])
				cond_r <= `VSC_CND_ANG;
			else
				cond_r <= `VSC_CND_FRQ;
		end
	end

	// ==========================================================
	// Synchroswitching estimates
	wire [16:0] ang_abs = ang_r[16] ? (17'h0 - ang_r) : ang_r;
	wire        frq_zero = (frq_r == 21'h0);
	wire [1:0]  sw_now = frq_zero ? `VSC_SW_STILL :
		((ang_r != 17'h0) && (ang_r[16] != frq_r[20])) ?
		`VSC_SW_ENCL : `VSC_SW_DEPART;
	wire [16:0] rem_ang = (sw_now == `VSC_SW_ENCL) ? ang_abs :
		(TURN17 - ang_abs);
	wire [20:0] frq_abs = frq_r[20] ? (21'h0 - frq_r) : frq_r;

	reg  [2:0]  fsm_r;
	reg         div_go_r;
	reg  [39:0] div_num_r;
	reg  [39:0] div_den_r;
	reg  [16:0] rot_r;
	reg  [16:0] close_r;
	reg  [1:0]  sw_r;
	wire        div_busy;
	wire        div_done;
	wire [39:0] div_quo;
	wire [16:0] quo_sat = (div_quo > SAT_STEPS) ? SAT_STEPS[16:0] :
		div_quo[16:0];
	// Full width product; a self-sized product would wrap at 17 bits
	wire [33:0] rot_prod = quo_sat * rem_ang;

	vsc_divider u_div
	(
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_start   (div_go_r),
		.i_num     (div_num_r),
		.i_den     (div_den_r),
		.o_busy    (div_busy),
		.o_done    (div_done),
		.o_quo     (div_quo)
	);

	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			fsm_r       <= ST_IDLE;
			div_go_r    <= 1'b0;
			div_num_r   <= 40'h0;
			div_den_r   <= 40'h0;
			rot_r       <= 17'h0;
			close_r     <= 17'h0;
			sw_r        <= `VSC_SW_STILL;
			o_close_cmd <= 1'b0;
		end
		else
		begin
			div_go_r    <= 1'b0;
			o_close_cmd <= 1'b0;
			case (fsm_r)
			ST_IDLE:
				// A tick during a running estimate is skipped
				if (tick_d_r)
				begin
					sw_r      <= auto_close_switching ? sw_now :
						`VSC_SW_STILL;
					div_num_r <= ROT_NUM;
					div_den_r <= {19'h0, frq_abs};
					div_go_r  <= 1'b1;
					fsm_r     <= ST_ROT;
				end
			ST_ROT:
				if (div_done)
				begin
					rot_r     <= quo_sat;
					div_num_r <= {6'h0, rot_prod};
					div_den_r <= FULL_TURN;
					div_go_r  <= 1'b1;
					fsm_r     <= ST_CLS;
				end
			ST_CLS:
				if (div_done)
				begin
					close_r <= (quo_sat > {1'b0, bk_time}) ?
						(quo_sat - {1'b0, bk_time}) : 17'h0;
					o_close_cmd <= auto_close_switching &
						o_sync_ok_output &
						(sw_r == `VSC_SW_ENCL) &
						(quo_sat <= {1'b0, bk_time});
					fsm_r <= ST_IDLE;
				end
			default:
				fsm_r <= ST_IDLE;
			endcase
		end
	end

	wire [20:0] ang_x = {{4{ang_r[16]}}, ang_r};
	wire [20:0] place = {ang_x[17:0], 3'h0} + {ang_x[19:0], 1'h0};

	// ==========================================================
	// Wishbone read data and acknowledge, one wait state
	reg [31:0] rd_mux;

	always @*
	begin
		rd_mux = 32'h0;
		case ({i_wb_adr[7:2], 2'b00})
		`VSC_CTRL_OFS:   rd_mux = ctrl;
		`VSC_LIVE_OFS:   rd_mux = cfg_r[1] & `VSC_HALF_MASK;
		`VSC_DEAD_OFS:   rd_mux = cfg_r[2] & `VSC_HALF_MASK;
		`VSC_MAXMAG_OFS: rd_mux = cfg_r[3] & `VSC_HALF_MASK;
		`VSC_MAXANG_OFS: rd_mux = cfg_r[4] & `VSC_HALF_MASK;
		`VSC_MAXFRQ_OFS: rd_mux = cfg_r[5] & `VSC_HALF_MASK;
		`VSC_BKTIME_OFS: rd_mux = cfg_r[6] & `VSC_HALF_MASK;
		`VSC_STAT_OFS:   rd_mux = {15'h0, div_busy, 2'h0, sw_r,
			2'h0, o_blocked, o_sync_ok_output, 1'b0, vst_r,
			1'b0, cond_r};
		`VSC_MAGD_OFS:   rd_mux = {{15{mag_r[16]}}, mag_r};
		`VSC_ANGD_OFS:   rd_mux = {{15{ang_r[16]}}, ang_r};
		`VSC_FRQD_OFS:   rd_mux = {{11{frq_r[20]}}, frq_r};
		`VSC_CLOSE_OFS:  rd_mux = {15'h0, close_r};
		`VSC_ROT_OFS:    rd_mux = {15'h0, rot_r};
		`VSC_PLACE_OFS:  rd_mux = {{11{place[20]}}, place};
		default:         rd_mux = 32'h0;
		endcase
	end

	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end
		else
		begin
			o_wb_ack <= wb_req;
			if (wb_req && !i_wb_we)
				o_wb_dat <= rd_mux;
		end
	end
endmodule // vsc_core

`default_nettype wire

// >>> test/vsc_core_chk.sv
// Checker on the synchrocheck core ports.
// Assumes one clock domain and the core's one-wait-state bus timing.
`timescale 1ns/10ps
`default_nettype none

module vsc_core_chk
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic i_meas_tick,
	input wire logic i_block,
	input wire logic o_sync_ok_output,
	input wire logic o_blocked,
	input wire logic o_close_cmd
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);

	// ==========================================================
	// Bus handshake
	a_ack_one_wait: assert property
		(i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");

	// ==========================================================
	// Sync and blocking outputs
	a_sync_cause: assert property ($rose(o_sync_ok_output)
		|-> $past(i_meas_tick, 2) && !$past(i_block, 2))
		else $error("sync ok rose without unblocked tick");
	a_block_cause: assert property ($rose(o_blocked)
		|-> $past(i_meas_tick, 2) && $past(i_block, 2))
		else $error("blocked rose without blocked tick");
	a_ok_drop: assert property
		(o_sync_ok_output && i_meas_tick && i_block
		|-> ##2 !o_sync_ok_output && !o_blocked)
		else $error("sync ok kept under late block");
	a_out_excl: assert property (!(o_sync_ok_output && o_blocked))
		else $error("sync ok and blocked together");
	a_out_hold: assert property
		($changed(o_sync_ok_output) || $changed(o_blocked)
		|-> $past(i_meas_tick, 2))
		else $error("output changed away from tick");
	a_close_synced: assert property (o_close_cmd |-> o_sync_ok_output)
		else $error("close command without sync ok");
	a_close_pulse: assert property (o_close_cmd |=> !o_close_cmd)
		else $error("close command longer than one cycle");
endmodule // vsc_core_chk

`default_nettype wire

// >>> test/vsc_meas_model.sv
// Measurement channels and blocking matrix seen by the core.
// Assumes the bench pulses i_go at most once per program cycle.
`timescale 1ns/10ps
`default_nettype none

module vsc_meas_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_go,
	input  wire logic [63:0] i_mag,
	input  wire logic [63:0] i_ang,
	input  wire logic [79:0] i_frq,
	input  wire logic        i_blk,
	output logic             o_tick,
	output logic [63:0]      o_mag,
	output logic [63:0]      o_ang,
	output logic [79:0]      o_frq,
	output logic             o_block
);
	logic tick_r;

	// ==========================================================
	// one strobe per program cycle
	always @(posedge i_clk_sys or posedge i_sys_rst)
		if (i_sys_rst)
			tick_r <= 1'b0;
		else
			tick_r <= i_go;

	// Values are stale off the strobe, so show them inverted there
	assign o_tick  = tick_r;
	assign o_mag   = tick_r ? i_mag : ~i_mag;
	assign o_ang   = tick_r ? i_ang : ~i_ang;
	assign o_frq   = tick_r ? i_frq : ~i_frq;
	assign o_block = tick_r ? i_blk : ~i_blk;
endmodule // vsc_meas_model

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the synchrocheck core.
// Assumes the core register map header and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "vsc_map.vh"

module tb_top;
	logic        i_clk_sys = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	logic        o_sync_ok_output;
	logic        o_blocked;
	logic        tick;
	logic        blk_in;
	logic        close;
	int          n_close = 0;
	logic        go = 1'b0;
	logic        blk = 1'b0;
	logic [63:0] mag = 64'h0;
	logic [63:0] ang = 64'h0;
	logic [79:0] frq = 80'h0;
	logic [63:0] m_mag;
	logic [63:0] m_ang;
	logic [79:0] m_frq;
	logic [31:0] seed = 32'd78;
	logic [31:0] rd;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cycles = 0;

	always #50 i_clk_sys = ~i_clk_sys;

	vsc_meas_model i_vsc_meas_model (.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst), .i_go(go), .i_mag(mag), .i_ang(ang),
		.i_frq(frq), .i_blk(blk), .o_tick(tick), .o_mag(m_mag),
		.o_ang(m_ang), .o_frq(m_frq), .o_block(blk_in));

	vsc_core i_vsc_core (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_meas_tick(tick),
		.i_channel_one_fundamental(m_mag[15:0]),
		.i_channel_two_fundamental(m_mag[31:16]),
		.i_channel_three_fundamental(m_mag[47:32]),
		.i_channel_four_fundamental(m_mag[63:48]),
		.i_ch1_ang(m_ang[15:0]), .i_ch2_ang(m_ang[31:16]),
		.i_ch3_ang(m_ang[47:32]), .i_ch4_ang(m_ang[63:48]),
		.i_ch1_frq(m_frq[19:0]), .i_ch2_frq(m_frq[39:20]),
		.i_ch3_frq(m_frq[59:40]), .i_ch4_frq(m_frq[79:60]),
		.i_block(blk_in), .o_sync_ok_output(o_sync_ok_output),
		.o_blocked(o_blocked), .o_close_cmd(close));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [2:0] exp_vst(input logic [15:0] r,
		input logic [15:0] c);
		if (r <= `VSC_LIVE_RST && r >= `VSC_DEAD_RST)
			return `VSC_VST_UNDEF;
		if (c <= `VSC_LIVE_RST && c >= `VSC_DEAD_RST)
			return `VSC_VST_UNDEF;
		return {1'b0, r > `VSC_LIVE_RST, c > `VSC_LIVE_RST};
	endfunction

	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		chk_reg({31'h0, g}, {31'h0, e});
	endtask

	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge i_clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// One program cycle: compared channel three against reference one
	task automatic run(input logic [15:0] rm, input int dm, da, df,
		input logic b, eo, eb, input logic [3:0] ec);
		logic [15:0] ra;
		logic [19:0] rf;
		logic [31:0] m;
		ra = 16'(rnd() % 6000) - 16'd3000;
		rf = 20'd50000 + 20'(rnd() % 1000);
		@(posedge i_clk_sys);
		mag <= {16'(rnd()), rm + 16'(dm), 16'(rnd()), rm};
		ang <= {16'(rnd()), ra + 16'(da), 16'(rnd()), ra};
		frq <= {20'(rnd()), rf + 20'(df), 20'(rnd()), rf};
		blk <= b;
		go <= 1'b1;
		@(posedge i_clk_sys);
		go <= 1'b0;
		repeat (95) @(posedge i_clk_sys);
		chk_bit(o_sync_ok_output, eo);
		chk_bit(o_blocked, eb);
		m = ec[3] ? 32'h370 : (ec == 4'h2 ? 32'h307 : 32'h377);
		wb(1'b0, `VSC_STAT_OFS, 32'h0, 4'hf);
		chk_reg(rd & m, {22'h0, eb, eo, 1'b0, exp_vst(rm, rm + 16'(dm)),
			1'b0, ec[2:0]} & m);
		wb(1'b0, `VSC_MAGD_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'(dm));
		wb(1'b0, `VSC_ANGD_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'(da));
		wb(1'b0, `VSC_FRQD_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'(df));
		wb(1'b0, `VSC_PLACE_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'(da * 10));
	endtask

	// ==========================================================
	// Hang guard, far above the expected run length
	always @(posedge i_clk_sys)
	begin
		cycles++;
		if (close === 1'b1)
			n_close++;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report;
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [31:0] rv [7];
		int dm;
		int da;
		int df;
		logic ok;
		rv = '{`VSC_CTRL_RST, `VSC_LIVE_RST, `VSC_DEAD_RST, `VSC_MAXMAG_RST,
			`VSC_MAXANG_RST, `VSC_MAXFRQ_RST, `VSC_BKTIME_RST};
		repeat (6) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			wb(1'b0, 8'(4 * i), 32'h0, 4'hf);
			chk_reg(rd, rv[i]);
		end
		wb(1'b1, 8'h40, 32'hffffffff, 4'hf);
		wb(1'b0, 8'h40, 32'h0, 4'hf);
		chk_reg(rd, 32'h0);
		wb(1'b1, `VSC_MAXMAG_OFS, 32'hdeadbeef, 4'h1);
		wb(1'b0, `VSC_MAXMAG_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'h000001ef);
		wb(1'b1, `VSC_MAXMAG_OFS, `VSC_MAXMAG_RST, 4'hf);
		// Stage disabled first, then stage one on ch3, ref ch1, LL only
		wb(1'b1, `VSC_CTRL_OFS, 32'h0000080a, 4'hf);
		run(16'd9000, 0, 0, 0, 1'b0, 1'b0, 1'b0, 4'h2);
		wb(1'b1, `VSC_CTRL_OFS, 32'h0000080b, 4'hf);
		run(16'd9000, 100, 200, 50, 1'b0, 1'b1, 1'b0, 4'h1);
		run(16'd9000, 100, 200, 50, 1'b1, 1'b0, 1'b0, 4'h8);
		run(16'd9000, 600, 0, 0, 1'b0, 1'b0, 1'b0, 4'h3);
		run(16'd9000, -100, -300, -20, 1'b1, 1'b0, 1'b1, 4'h0);
		run(16'd9000, 0, 0, 0, 1'b0, 1'b0, 1'b1, 4'h0);
		run(16'd9000, 0, 1500, 0, 1'b1, 1'b0, 1'b0, 4'h4);
		run(16'd9000, 0, 0, 150, 1'b0, 1'b0, 1'b0, 4'h5);
		run(16'd2000, 50, 0, 0, 1'b0, 1'b0, 1'b0, 4'h7);
		run(16'd5000, 0, 0, 0, 1'b0, 1'b0, 1'b0, 4'h7);
		run(16'd9000, -7000, 0, 0, 1'b0, 1'b0, 1'b0, 4'h7);
		// Odd deltas never land on a limit exactly
		for (int i = 0; i < 16; i++)
		begin
			dm = 2 * int'(rnd() % 600) - 599;
			da = 2 * int'(rnd() % 1200) - 1199;
			df = 2 * int'(rnd() % 120) - 119;
			ok = dm < 500 && dm > -500 && da < 1000 && da > -1000 &&
				df < 100 && df > -100;
			run(16'(9000 + rnd() % 500), dm, da, df, 1'b0, ok, 1'b0,
				ok ? 4'h1 : 4'h8);
		end
		// Enclosing inside breaker time closes, departing does not
		wb(1'b1, `VSC_CTRL_OFS, 32'h0000084b, 4'hf);
		run(16'd9000, 0, -50, 50, 1'b0, 1'b1, 1'b0, 4'h1);
		wb(1'b0, `VSC_STAT_OFS, 32'h0, 4'hf);
		chk_reg(rd[13:12], `VSC_SW_ENCL);
		wb(1'b0, `VSC_CLOSE_OFS, 32'h0, 4'hf);
		chk_reg(rd, 32'h0);
		run(16'd9000, 0, 200, 50, 1'b0, 1'b1, 1'b0, 4'h1);
		wb(1'b0, `VSC_STAT_OFS, 32'h0, 4'hf);
		chk_reg(rd[13:12], `VSC_SW_DEPART);
		wb(1'b0, `VSC_ROT_OFS, 32'h0, 4'hf);
		chk_reg(rd, `VSC_ROT_NUM / 50);
		wb(1'b0, `VSC_CLOSE_OFS, 32'h0, 4'hf);
		chk_reg(rd, (`VSC_ROT_NUM / 50) * (`VSC_FULL_TURN - 200) /
			`VSC_FULL_TURN - `VSC_BKTIME_RST);
		chk_reg(n_close, 32'd1);
		final_report;
	end
endmodule // tb_top

bind vsc_core vsc_core_chk i_vsc_core_chk (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.o_wb_ack(o_wb_ack), .i_meas_tick(i_meas_tick), .i_block(i_block),
	.o_sync_ok_output(o_sync_ok_output), .o_blocked(o_blocked),
	.o_close_cmd(o_close_cmd));

`default_nettype wire
